// ---- htc_pkg.sv ----
// Contract
// - hardware mode hands control to strap pins
// - transmit PLL always fed from external clock
// - selects 00 pick external transmit clock
// - selects 01 pick transmit PLL clock
// - selects 10 pick prescaled master clock
// - selects 11 pick recovered receive clock
// - PLL output pin mirrors selected transmit clock
// - termination set from selected operating modes
// - transmit termination disable strap: 0 on, 1 off
// - receive termination disable strap: 0 on, 1 off
// - E1 impedance strap: 0 75 ohm, 1 120 ohm
// - one impedance strap serves both directions
package htc_pkg;
    // ==========================================================
    // register map (byte addresses, one aligned word each)
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0; // software control
    localparam logic [ADDR_W-1:0] OFS_PRESC = 4'h4; // master clock prescaler
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8; // read-only state
    // ==========================================================
    // control word fields
    localparam int CTRL_SEL_LO = 0;
    localparam int CTRL_SEL_HI = 1;
    localparam int CTRL_TTD = 2;
    localparam int CTRL_RTD = 3;
    localparam int CTRL_E1IMP = 4;
    localparam int CTRL_TMODE = 8; // 4-bit field base
    localparam int CTRL_RMODE = 12; // 4-bit field base
    localparam logic [31:0] CTRL_RESET = 32'h0000000C; // terminations off
    localparam logic [15:0] PRESC_RESET = 16'h0001; // half period in mclk edges
    // ==========================================================
    // status word fields
    localparam int STAT_HW = 0;
    localparam int STAT_SEL = 1; // 2-bit active select
    localparam int STAT_SWITCH = 3;
    localparam int STAT_TTERM = 4; // 3-bit
    localparam int STAT_RTERM = 8; // 3-bit
    // ==========================================================
    // strap and mode codes
    localparam logic [1:0] HW_MODE_CODE = 2'h3; // host port selects for hw mode
    localparam logic [1:0] SEL_EXT = 2'h0;
    localparam logic [1:0] SEL_PLL = 2'h1;
    localparam logic [1:0] SEL_MCLK = 2'h2;
    localparam logic [1:0] SEL_RCLK = 2'h3;
    localparam logic [3:0] MODE_J1_FIRST = 4'h2;
    localparam logic [3:0] MODE_E1_FIRST = 4'h4;
    localparam logic [3:0] MODE_E1_LAST = 4'h8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================================
    // termination values
    typedef enum logic [2:0] {TERM_OFF, TERM_75, TERM_100, TERM_110, TERM_120} htc_term_e;

    // termination from mode, disable and impedance select
    function automatic htc_term_e htc_term(input logic [3:0] mode, input logic dis, input logic imp);
        htc_term_e t;
        t = TERM_OFF;
        if (dis) begin // disabled at 1
            t = TERM_OFF;
        end else if (mode < MODE_J1_FIRST) begin // T1
            t = TERM_100;
        end else if (mode < MODE_E1_FIRST) begin // J1
            t = TERM_110;
        end else if (mode <= MODE_E1_LAST) begin // E1 family
            t = imp ? TERM_120 : TERM_75;
        end
        return t;
    endfunction : htc_term
endpackage : htc_pkg

// ---- htc_sync.sv ----
`timescale 1ns/10ps
// two-flop synchroniser, one per bit
module htc_sync #(
    parameter int W = 1
) (
    input wire logic clk, // system clock
    input wire logic rst, // synchronous reset
    input wire logic ce, // clock enable
    input wire logic [W-1:0] d, // asynchronous levels
    output logic [W-1:0] q // synchronised levels
);
    // ==========================================================
    // per-bit flop pairs; first stage feeds only the second
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic meta; // first stage
            always_ff @(posedge clk) begin
                if (rst) begin
                    meta <= 1'b0;
                    q[i] <= 1'b0;
                end else if (ce) begin
                    meta <= d[i];
                    q[i] <= meta;
                end
            end
        end
    endgenerate
endmodule : htc_sync

// ---- htc_clk_mux.sv ----
`timescale 1ns/10ps
// glitch-free four-way clock selector on sampled clock levels
module htc_clk_mux (
    input wire logic clk, // system clock
    input wire logic rst, // synchronous reset
    input wire logic ce, // clock enable
    input wire logic [1:0] req_sel, // requested source
    input wire logic [3:0] src, // synchronised source levels
    output logic clk_out, // selected clock, registered
    output logic [1:0] cur_sel, // source now driving
    output logic switching // parked low between sources
);
    typedef enum logic {RUN, HOLD} htc_mux_e;
    htc_mux_e state; // switch state

    // ==========================================================
    // leave the old source only on its low phase, join the new one only on its low phase,
    // so no shortened high pulse reaches the transmitter
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= RUN;
            cur_sel <= 2'h0;
            clk_out <= 1'b0;
        end else if (ce) begin
            case (state)
                RUN: begin
                    clk_out <= src[cur_sel];
                    if (req_sel != cur_sel && !src[cur_sel]) begin
                        state <= HOLD;
                        clk_out <= 1'b0;
                    end
                end
                HOLD: begin
                    clk_out <= 1'b0;
                    if (!src[req_sel]) begin
                        cur_sel <= req_sel;
                        state <= RUN;
                    end
                end
                default: begin
                    state <= RUN;
                end
            endcase
        end
    end

    assign switching = (state == HOLD);

    // ==========================================================
    // checks
    property p_hold_low;
        @(posedge clk) disable iff (rst) switching && $past(switching) |-> !clk_out;
    endproperty
    a_hold_low: assert property (p_hold_low) else $error("clock not parked low while switching");
endmodule : htc_clk_mux

// ---- htc_top.sv ----
`timescale 1ns/10ps
// hardware-mode transmit clock and termination control with AXI4-Lite access
module htc_top (
    input wire logic clk, // 10 MHz system clock
    input wire logic rst, // synchronous reset, high
    input wire logic ce, // clock enable, freezes state when low
    // straps
    input wire logic host_port_sel_lo, // host port select strap 0
    input wire logic host_port_sel_hi, // host port select strap 1
    input wire logic tx_clk_src_sel_lo, // transmit clock select strap 0
    input wire logic tx_clk_src_sel_hi, // transmit clock select strap 1
    input wire logic tx_term_disable, // transmit termination disable strap
    input wire logic rx_term_disable, // receive termination disable strap
    input wire logic e1_impedance_select, // 0 75 ohm, 1 120 ohm
    input wire logic [3:0] tx_mode_straps, // transmit mode select
    input wire logic [3:0] rx_mode_straps, // receive mode select
    // clock sources, sampled as levels
    input wire logic ext_tx_clock_in, // external transmit clock pin
    input wire logic tx_pll_clk_in, // transmit PLL output clock
    input wire logic mclk_in, // master clock
    input wire logic rx_rec_clk_in, // recovered receive clock
    // transmit path and terminations
    output logic tx_pll_ref, // transmit PLL reference
    output logic tx_clock, // selected transmit clock
    output logic pll_clk_out, // PLL clock output pin
    output htc_pkg::htc_term_e tx_term, // transmit termination
    output htc_pkg::htc_term_e rx_term, // receive termination
    // AXI4-Lite slave
    input wire logic [htc_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // byte enables
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [htc_pkg::ADDR_W-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready // read data ready
);
    // ==========================================================
    // declarations
    logic [31:0] ctrl; // software control word
    logic [15:0] presc; // master clock half-period in sampled edges
    logic [15:0] div_cnt; // prescaler counter
    logic mclk_div; // prescaled master clock
    logic mclk_last; // previous sampled master clock
    logic [14:0] straps_s; // synchronised straps
    logic [3:0] src_s; // synchronised clock levels
    logic hw_mode; // hardware controller mode
    logic [1:0] eff_sel; // effective clock select
    logic eff_ttd; // effective transmit termination disable
    logic eff_rtd; // effective receive termination disable
    logic eff_imp; // effective E1 impedance select
    logic [3:0] eff_tmode; // effective transmit mode
    logic [3:0] eff_rmode; // effective receive mode
    logic [1:0] cur_sel; // mux source in use
    logic switching; // mux parked between sources
    logic [3:0] src_vec; // mux inputs
    logic aw_held; // write address captured
    logic w_held; // write data captured
    logic [htc_pkg::ADDR_W-1:0] aw_addr; // captured write address
    logic [31:0] w_data; // captured write data
    logic [3:0] w_strb; // captured byte enables
    logic [31:0] status; // status word
    logic [31:0] next_ctrl; // control after byte merge
    logic [31:0] next_presc; // prescaler after byte merge

    // ==========================================================
    // synchronisers: straps and clock levels come from outside
    htc_sync #(.W(15)) u_strap_sync (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .d({host_port_sel_hi, host_port_sel_lo, tx_clk_src_sel_hi, tx_clk_src_sel_lo, tx_term_disable,
            rx_term_disable, e1_impedance_select, tx_mode_straps, rx_mode_straps}),
        .q(straps_s)
    );

    htc_sync #(.W(4)) u_clk_sync (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .d({rx_rec_clk_in, mclk_in, tx_pll_clk_in, ext_tx_clock_in}),
        .q(src_s)
    );

    // ==========================================================
    // mode and effective settings: straps in hardware mode, software otherwise
    assign hw_mode = (straps_s[14:13] == htc_pkg::HW_MODE_CODE);
    assign eff_sel = hw_mode ? straps_s[12:11] :
        {ctrl[htc_pkg::CTRL_SEL_HI], ctrl[htc_pkg::CTRL_SEL_LO]};
    assign eff_ttd = hw_mode ? straps_s[10] : ctrl[htc_pkg::CTRL_TTD];
    assign eff_rtd = hw_mode ? straps_s[9] : ctrl[htc_pkg::CTRL_RTD];
    assign eff_imp = hw_mode ? straps_s[8] : ctrl[htc_pkg::CTRL_E1IMP];
    assign eff_tmode = hw_mode ? straps_s[7:4] : ctrl[htc_pkg::CTRL_TMODE +: 4];
    assign eff_rmode = hw_mode ? straps_s[3:0] : ctrl[htc_pkg::CTRL_RMODE +: 4];

    // ==========================================================
    // master clock prescaler: counts sampled rising edges;
    // limited to master clocks well below half the system clock
    always_ff @(posedge clk) begin
        if (rst) begin
            mclk_last <= 1'b0;
            div_cnt <= 16'h0000;
            mclk_div <= 1'b0;
        end else if (ce) begin
            mclk_last <= src_s[2];
            if (src_s[2] && !mclk_last) begin
                if (div_cnt + 16'h0001 >= presc) begin
                    div_cnt <= 16'h0000;
                    mclk_div <= !mclk_div;
                end else begin
                    div_cnt <= div_cnt + 16'h0001;
                end
            end
        end
    end

    // ==========================================================
    // transmit clock selection
    assign src_vec = {src_s[3], mclk_div, src_s[1], src_s[0]};

    htc_clk_mux u_mux (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .req_sel(eff_sel),
        .src(src_vec),
        .clk_out(tx_clock),
        .cur_sel(cur_sel),
        .switching(switching)
    );

    // PLL output pin follows the selected transmit clock
    assign pll_clk_out = tx_clock;

    // PLL reference: always the external transmit clock pin, no alternative
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_pll_ref <= 1'b0;
        end else if (ce) begin
            tx_pll_ref <= src_s[0];
        end
    end

    // ==========================================================
    // termination decode; one impedance select feeds both paths
    // registered so the termination switches see one clean change per strap update
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_term <= htc_pkg::TERM_OFF;
            rx_term <= htc_pkg::TERM_OFF;
        end else if (ce) begin
            tx_term <= htc_pkg::htc_term(eff_tmode, eff_ttd, eff_imp);
            rx_term <= htc_pkg::htc_term(eff_rmode, eff_rtd, eff_imp);
        end
    end

    // ==========================================================
    // AXI4-Lite write: address and data taken in either order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;

    always_ff @(posedge clk) begin
        if (rst) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= htc_pkg::RESP_OKAY;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (aw_held && w_held) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // unmapped and read-only addresses answer with an error
                s_axi_bresp <= (aw_addr[htc_pkg::ADDR_W-1:2] == htc_pkg::OFS_CTRL[htc_pkg::ADDR_W-1:2] ||
                    aw_addr[htc_pkg::ADDR_W-1:2] == htc_pkg::OFS_PRESC[htc_pkg::ADDR_W-1:2]) ?
                    htc_pkg::RESP_OKAY : htc_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // byte-lane merge for the writable words
    always_comb begin
        next_ctrl = ctrl;
        next_presc = {16'h0000, presc};
        for (int b = 0; b < 4; b++) begin
            if (w_strb[b]) begin
                next_ctrl[b*8 +: 8] = w_data[b*8 +: 8];
                next_presc[b*8 +: 8] = w_data[b*8 +: 8];
            end
        end
    end

    // register store
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl <= htc_pkg::CTRL_RESET;
            presc <= htc_pkg::PRESC_RESET;
        end else if (ce && aw_held && w_held) begin
            if (aw_addr[htc_pkg::ADDR_W-1:2] == htc_pkg::OFS_CTRL[htc_pkg::ADDR_W-1:2]) begin
                ctrl <= next_ctrl;
            end
            if (aw_addr[htc_pkg::ADDR_W-1:2] == htc_pkg::OFS_PRESC[htc_pkg::ADDR_W-1:2]) begin
                presc <= next_presc[15:0];
            end
        end
    end

    // ==========================================================
    // AXI4-Lite read: one cycle to data
    always_comb begin
        status = 32'h00000000;
        status[htc_pkg::STAT_HW] = hw_mode;
        status[htc_pkg::STAT_SEL +: 2] = cur_sel;
        status[htc_pkg::STAT_SWITCH] = switching;
        status[htc_pkg::STAT_TTERM +: 3] = 3'(tx_term);
        status[htc_pkg::STAT_RTERM +: 3] = 3'(rx_term);
    end

    // no wait states: data stand one edge after the address is taken
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= htc_pkg::RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= htc_pkg::RESP_OKAY;
                case (s_axi_araddr[htc_pkg::ADDR_W-1:2])
                    htc_pkg::OFS_CTRL[htc_pkg::ADDR_W-1:2]: begin
                        s_axi_rdata <= ctrl;
                    end
                    htc_pkg::OFS_PRESC[htc_pkg::ADDR_W-1:2]: begin
                        s_axi_rdata <= {16'h0000, presc};
                    end
                    htc_pkg::OFS_STATUS[htc_pkg::ADDR_W-1:2]: begin
                        s_axi_rdata <= status;
                    end
                    default: begin // unmapped: zero data, error
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= htc_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // checks
    // settled means the mux itself runs on the source, not just that it was asked for:
    // while an old source is still high the output legally keeps following it
    sequence s_settled(logic [1:0] code);
        ce && cur_sel == code && !switching;
    endsequence

    // the select must be the strap pins as they stood two enabled edges back,
    // so a broken synchroniser or a wrong bit slice shows up here
    property p_hw_straps;
        @(posedge clk) disable iff (rst) $past(ce) && $past(ce, 2) && hw_mode
            |-> eff_sel == $past({tx_clk_src_sel_hi, tx_clk_src_sel_lo}, 2);
    endproperty
    a_hw_straps: assert property (p_hw_straps) else $error("hardware mode not steered by straps");

    property p_pll_ref;
        @(posedge clk) disable iff (rst) $past(ce) |-> tx_pll_ref == $past(src_s[0]);
    endproperty
    a_pll_ref: assert property (p_pll_ref) else $error("PLL reference not the external clock");

    property p_sel_ext;
        @(posedge clk) disable iff (rst) s_settled(htc_pkg::SEL_EXT) ##1 ce |-> tx_clock == $past(src_s[0]);
    endproperty
    a_sel_ext: assert property (p_sel_ext) else $error("select 00 not external clock");

    property p_sel_pll;
        @(posedge clk) disable iff (rst) s_settled(htc_pkg::SEL_PLL) ##1 ce |-> tx_clock == $past(src_s[1]);
    endproperty
    a_sel_pll: assert property (p_sel_pll) else $error("select 01 not PLL clock");

    property p_sel_mclk;
        @(posedge clk) disable iff (rst) s_settled(htc_pkg::SEL_MCLK) ##1 ce |-> tx_clock == $past(mclk_div);
    endproperty
    a_sel_mclk: assert property (p_sel_mclk) else $error("select 10 not prescaled master clock");

    property p_sel_rclk;
        @(posedge clk) disable iff (rst) s_settled(htc_pkg::SEL_RCLK) ##1 ce |-> tx_clock == $past(src_s[3]);
    endproperty
    a_sel_rclk: assert property (p_sel_rclk) else $error("select 11 not recovered clock");

    property p_pll_pin;
        @(posedge clk) disable iff (rst) pll_clk_out == tx_clock;
    endproperty
    a_pll_pin: assert property (p_pll_pin) else $error("PLL pin differs from transmit clock");

    property p_tx_term_dis;
        @(posedge clk) disable iff (rst) ce && eff_ttd ##1 1'b1 |-> tx_term == htc_pkg::TERM_OFF;
    endproperty
    a_tx_term_dis: assert property (p_tx_term_dis) else $error("transmit termination not disabled");

    property p_rx_term_dis;
        @(posedge clk) disable iff (rst) ce && !eff_rtd && eff_rmode < htc_pkg::MODE_J1_FIRST ##1 1'b1
            |-> rx_term == htc_pkg::TERM_100;
    endproperty
    a_rx_term_dis: assert property (p_rx_term_dis) else $error("receive termination not enabled");

    property p_e1_imp;
        @(posedge clk) disable iff (rst) ce && !eff_ttd && eff_tmode >= htc_pkg::MODE_E1_FIRST &&
            eff_tmode <= htc_pkg::MODE_E1_LAST ##1 1'b1
            |-> tx_term == ($past(eff_imp) ? htc_pkg::TERM_120 : htc_pkg::TERM_75);
    endproperty
    a_e1_imp: assert property (p_e1_imp) else $error("E1 impedance wrong");

    property p_e1_both;
        @(posedge clk) disable iff (rst) tx_term inside {htc_pkg::TERM_75, htc_pkg::TERM_120} &&
            rx_term inside {htc_pkg::TERM_75, htc_pkg::TERM_120} |-> tx_term == rx_term;
    endproperty
    a_e1_both: assert property (p_e1_both) else $error("E1 terminations differ");
endmodule : htc_top

// ---- htc_src_model.sv ----
`timescale 1ns/10ps
// ====
// board clock sources, free-running square waves
module htc_src_model (
    input wire logic clk, // system clock
    input wire logic tie_rec, // board strap of recovered clock onto the pin
    output logic ext_tx_clock_in, // transmit clock pin
    output logic tx_pll_clk_in, // transmit PLL clock
    output logic mclk_in, // master clock
    output logic rx_rec_clk_in // recovered clock
);
    int n = 0; // cycle count
    // distinct periods keep the edge counts of the sources apart
    always_ff @(posedge clk) begin
        n <= n + 1;
    end
    assign rx_rec_clk_in = (n % 24) < 12;
    assign tx_pll_clk_in = (n % 14) < 7;
    assign mclk_in = (n % 10) < 5;
    assign ext_tx_clock_in = tie_rec ? rx_rec_clk_in : (n % 8) < 4;
endmodule : htc_src_model

// ---- htc_top_tb.sv ----
`timescale 1ns/10ps
// ====
// bench: register access, strap decode, clock selection
module htc_top_tb;
    logic clk = '0, rst = 1'h1, ce = 1'h1, tie_rec = '0; // clock, reset, enable, board link
    logic host_port_sel_lo = '0, host_port_sel_hi = '0, tx_clk_src_sel_lo = '0, tx_clk_src_sel_hi = '0;
    logic tx_term_disable = '0, rx_term_disable = '0, e1_impedance_select = '0; // termination straps
    logic [3:0] tx_mode_straps = '0, rx_mode_straps = '0, s_axi_wstrb = 4'hF; // modes, byte enables
    logic ext_tx_clock_in, tx_pll_clk_in, mclk_in, rx_rec_clk_in, tx_pll_ref, tx_clock, pll_clk_out;
    htc_pkg::htc_term_e tx_term, rx_term; // termination outputs
    logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0; // addresses
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd; // data, last read word
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp; // responses, last response
    logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid; // slave handshakes
    int errors = 0, checked = 0, ct, cp, cr; // tallies, edge counts
    int exp_cnt [5] = '{105, 60, 42, 35, 35}; // rising edges in 840 cycles per source, last with board tie
    htc_src_model u_htc_src_model (.*);
    htc_top u_htc_top (.*);
    always #50 clk = ~clk; // 10 MHz
    // ====
    // reporting
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_sim
    task automatic cmp_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask : cmp_word
    task automatic cmp_term(input string nm, input htc_pkg::htc_term_e e, input htc_pkg::htc_term_e g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s exp %0d got %0d", nm, e, g);
        end
    endtask : cmp_term
    // a wait that ran out ends the run
    task automatic tmo(input int n);
        if (n >= 50) begin
            errors++;
            $display("MISMATCH handshake exp answer got none");
            end_sim();
        end
    endtask : tmo
    // ====
    // AXI4-Lite master, holds each channel until its ready
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        tmo(n);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask : axi_wr
    task automatic axi_rd(input logic [3:0] a);
        int n;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        tmo(n);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask : axi_rd
    // expected termination: T1 100, J1 110, E1 by impedance strap, others off
    function automatic htc_pkg::htc_term_e xterm(input logic [3:0] m, input logic dis, input logic imp);
        if (dis || m > 4'h8) return htc_pkg::TERM_OFF;
        if (m < 4'h2) return htc_pkg::TERM_100;
        if (m < 4'h4) return htc_pkg::TERM_110;
        return imp ? htc_pkg::TERM_120 : htc_pkg::TERM_75;
    endfunction : xterm
    // a window of whole periods gives an exact edge count whatever the phase
    task automatic count_edges;
        logic pc, pp, pr;
        ct = 0;
        cp = 0;
        cr = 0;
        @(posedge clk);
        {pc, pp, pr} = {tx_clock, pll_clk_out, tx_pll_ref};
        repeat (840) begin
            @(posedge clk);
            ct += ({tx_clock, pc} === 2'h2);
            cp += ({pll_clk_out, pp} === 2'h2);
            cr += ({tx_pll_ref, pr} === 2'h2);
            {pc, pp, pr} = {tx_clock, pll_clk_out, tx_pll_ref};
        end
    endtask : count_edges
    // ====
    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        cmp_term("tx_term", htc_pkg::TERM_OFF, tx_term);
        axi_rd(htc_pkg::OFS_CTRL);
        cmp_word("ctrl", htc_pkg::CTRL_RESET, rd);
        axi_rd(htc_pkg::OFS_PRESC);
        cmp_word("presc", 32'(htc_pkg::PRESC_RESET), rd);
        axi_rd(4'hC);
        cmp_word("unmapped", 32'(htc_pkg::RESP_SLVERR), 32'(rsp));
        $display("test reset done");
        axi_wr(htc_pkg::OFS_STATUS, 32'h0);
        cmp_word("ro write", 32'(htc_pkg::RESP_SLVERR), 32'(rsp));
        axi_wr(htc_pkg::OFS_CTRL, 32'h00004510);
        axi_rd(htc_pkg::OFS_CTRL);
        cmp_word("ctrl", 32'h00004510, rd);
        repeat (4) @(posedge clk);
        cmp_term("rx_term", htc_pkg::TERM_120, rx_term);
        axi_rd(htc_pkg::OFS_STATUS);
        cmp_word("status", 32'h00000440, rd);
        $display("test software control done");
        host_port_sel_lo <= 1'h1;
        host_port_sel_hi <= 1'h1;
        for (int i = 0; i < 64; i++) begin
            tx_mode_straps <= 4'(i);
            rx_mode_straps <= 4'(i);
            e1_impedance_select <= i[4];
            tx_term_disable <= i[5];
            rx_term_disable <= i[5] ^ i[0];
            repeat (4) @(posedge clk);
            cmp_term("tx_term", xterm(4'(i), i[5], i[4]), tx_term);
            cmp_term("rx_term", xterm(4'(i), i[5] ^ i[0], i[4]), rx_term);
        end
        ce <= 1'h0;
        tx_term_disable <= 1'h0;
        tx_mode_straps <= 4'h0;
        repeat (8) @(posedge clk);
        cmp_term("frozen tx_term", htc_pkg::TERM_OFF, tx_term);
        ce <= 1'h1;
        repeat (4) @(posedge clk);
        cmp_term("thawed tx_term", htc_pkg::TERM_100, tx_term);
        $display("test terminations done");
        for (int s = 0; s < 5; s++) begin
            tx_clk_src_sel_lo <= s[0];
            tx_clk_src_sel_hi <= s[1];
            tie_rec <= s[2];
            repeat (120) @(posedge clk);
            count_edges();
            cmp_word("tx_clock", exp_cnt[s], ct);
            cmp_word("pll_out", exp_cnt[s], cp);
            cmp_word("pll_ref", exp_cnt[s & 4], cr);
        end
        axi_rd(htc_pkg::OFS_STATUS);
        cmp_word("hw mode", 32'h1, rd & 32'h1);
        $display("test clock select done");
        end_sim();
    end
endmodule : htc_top_tb
